// [dv/csc_ctrl_assertions.sv]
// Concurrent checks on the guard drivers and the bus data pin.
`timescale 1ns/1ps
module csc_ctrl_assertions (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Observed inputs
   input wire logic i_scl,
   input wire logic i_active,
   input wire logic [3:0] i_excite,
   // Observed outputs
   input wire logic o_sda_oe,
   input wire csc_pkg::csc_guard_s o_first_guard_output,
   input wire csc_pkg::csc_guard_s o_second_guard_output,
   input wire logic o_guard_short
);
   // ******
   // Helpers
   // ******
   wire csc_pkg::csc_guard_s g1 = o_first_guard_output;
   wire csc_pkg::csc_guard_s g2 = o_second_guard_output;
   logic [3:0] excite_reg;
   always_ff @(posedge i_mclk)
      excite_reg <= i_excite;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);
   sequence s_scl_high2;
      i_scl [*2];
   endsequence
   // ******
   // Properties
   // ******
   property p_g1_level;
      g1.level == (g1.en & excite_reg[g1.src]);
   endproperty
   a_g1_level: assert property (p_g1_level)
      else $error("first guard level does not follow its input");
   property p_g2_level;
      g2.level == (g2.en & excite_reg[g2.src]);
   endproperty
   a_g2_level: assert property (p_g2_level)
      else $error("second guard level does not follow its input");
   property p_short;
      o_guard_short |-> g1.en && g2.en && g1.src == g2.src;
   endproperty
   a_short: assert property (p_short)
      else $error("tied guards differ");
   property p_order;
      g1.en && g2.en && !o_guard_short |-> g1.src <= g2.src;
   endproperty
   a_order: assert property (p_order)
      else $error("guard inputs out of order");
   property p_g2_needs_g1;
      g2.en |-> g1.en;
   endproperty
   a_g2_needs_g1: assert property (p_g2_needs_g1)
      else $error("second guard active alone");
   property p_idle;
      !i_active |=> !g1.en && !g2.en && !o_guard_short;
   endproperty
   a_idle: assert property (p_idle)
      else $error("guard driven without measurement");
   property p_reset;
      disable iff (1'b0)
      !i_rst_b |=> {o_sda_oe, o_guard_short, g1, g2} == 10'h000;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not cleared by reset");
   property p_oe_quiet;
      s_scl_high2 |-> $stable(o_sda_oe);
   endproperty
   a_oe_quiet: assert property (p_oe_quiet)
      else $error("data pin moved while clock high");
   property p_oe_moves;
      $changed(o_sda_oe) |-> !i_scl && !$past(i_scl);
   endproperty
   a_oe_moves: assert property (p_oe_moves)
      else $error("data pin moved outside clock low");
endmodule
bind csc_ctrl csc_ctrl_assertions csc_ctrl_assertions_i (.i_mclk, .i_rst_b,
   .i_scl, .i_active, .i_excite, .o_sda_oe, .o_first_guard_output,
   .o_second_guard_output, .o_guard_short);

// [dv/csc_ctrl_tb_top.sv]
// Self-checking bench for the capacitive sense control block.
`timescale 1ns/1ps
module csc_ctrl_tb_top;
   // ******
   // Stimulus and wiring
   // ******
   localparam logic [6:0] DEV = 7'h50;
   localparam logic [15:0] OTP = 16'h3c5a;
   localparam logic [15:0] STEP = 16'h0800;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_conv_valid = 1'b0;
   logic [1:0] i_conv_meas = 2'h0;
   logic signed [23:0] i_conv_raw = 24'h00_0000;
   logic i_active = 1'b0;
   logic [1:0] i_active_meas = 2'h0;
   logic [3:0] i_excite = 4'h0;
   logic scl, sda_low, sda_oe, sda_o, gshort;
   wire logic sda = !(sda_low || sda_oe);
   csc_pkg::csc_guard_s g1, g2;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [2:0] c_pos[4] = '{3'h1, 3'h2, 3'h3, 3'h0};
   logic [2:0] c_neg[4] = '{3'h7, 3'h4, 3'h7, 3'h3};
   logic [4:0] c_code[4] = '{5'h00, 5'h01, 5'h1f, 5'h09};
   logic signed [23:0] c_raw[4] = '{24'h01_2345, 24'h10_0000,
                                    24'h40_0000, 24'h00_1000};
   logic signed [15:0] c_off[4] = '{16'h0010, 16'hfff0, 16'h0000, 16'h0100};
   logic [15:0] c_gain[4] = '{16'h4000, 16'h2000, 16'h4000, 16'h4000};
   logic [2:0] x1[4] = '{3'h5, 3'h6, 3'h5, 3'h0};
   logic [2:0] x2[4] = '{3'h5, 3'h0, 3'h7, 3'h0};
   always #20 i_mclk = ~i_mclk;
   csc_ctrl #(.BUS_ADDR(DEV), .DAC_STEP(STEP)) csc_ctrl_i (.i_mclk(i_mclk),
      .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe), .i_otp_gain(OTP), .i_conv_valid(i_conv_valid),
      .i_conv_meas(i_conv_meas), .i_conv_raw(i_conv_raw),
      .i_active(i_active), .i_active_meas(i_active_meas),
      .i_excite(i_excite), .o_first_guard_output(g1),
      .o_second_guard_output(g2), .o_guard_short(gshort));
   csc_host #(.ADDR(DEV)) csc_host_i (.i_mclk(i_mclk), .i_sda(sda),
      .o_scl(scl), .o_sda_low(sda_low));
   // ******
   // Tasks
   // ******
   task automatic chk(input string n, input logic [15:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_g(input string n, input csc_pkg::csc_guard_s e, g);
      checks_done++;
      if (g.en !== e.en || g.level !== e.level || (e.en && g.src !== e.src))
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] p, input logic [15:0] v);
      logic [3:0] a;
      csc_host_i.wr(DEV, p, v, a);
      chk($sformatf("write ack %h", p), 16'h000f, 16'(a));
   endtask
   task automatic rd_reg(input logic [7:0] p, input logic [15:0] e);
      logic [15:0] v;
      csc_host_i.rd(p, v);
      chk($sformatf("register %h", p), e, v);
   endtask
   task automatic do_reset;
      @(negedge i_mclk);
      i_rst_b = 1'b0;
      repeat (2) @(negedge i_mclk);
      i_rst_b = 1'b1;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // The ceiling sits well above the roughly 41000 cycles the tests need.
   always @(posedge i_mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         num_errors++;
         summarize;
      end
   end
   // ******
   // Tests
   // ******
   initial
   begin
      longint m;
      logic [23:0] r;
      logic [3:0] a, ex;
      csc_pkg::csc_guard_s e1, e2;
      do_reset;
      for (int k = 0; k < 4; k++)
      begin
         rd_reg(8'h0d + 8'(k), 16'h0000);
         rd_reg(8'h11 + 8'(k), OTP);
      end
      $display("test reset_defaults done");
      csc_host_i.glitch = 1'b1;
      for (int k = 0; k < 4; k++)
         wr_reg(8'h11 + 8'(k), 16'h1111 * 16'(k + 1));
      csc_host_i.glitch = 1'b0;
      for (int k = 0; k < 4; k++)
         rd_reg(8'h11 + 8'(k), 16'h1111 * 16'(k + 1));
      $display("test gain_trims done");
      csc_host_i.wr(DEV, 8'h0c, 16'h1234, a);
      chk("unmapped ack", 16'h0008, 16'(a));
      csc_host_i.wr(DEV, 8'h15, 16'h1234, a);
      chk("past end ack", 16'h0008, 16'(a));
      csc_host_i.wr(DEV, 8'h00, 16'h1234, a);
      chk("result ack", 16'h000c, 16'(a));
      csc_host_i.wr(DEV ^ 7'h01, 8'h11, 16'h1234, a);
      chk("foreign ack", 16'h0000, 16'(a));
      rd_reg(8'h00, 16'h0000);
      rd_reg(8'h11, 16'h1111);
      $display("test refusals done");
      for (int k = 0; k < 4; k++)
      begin
         wr_reg(8'h08 + 8'(k), {c_pos[k], c_neg[k], c_code[k], 5'h00});
         wr_reg(8'h0d + 8'(c_pos[k]), c_off[k]);
         wr_reg(8'h11 + 8'(c_pos[k]), c_gain[k]);
         @(negedge i_mclk);
         i_conv_meas = 2'(k);
         i_conv_raw = c_raw[k];
         i_conv_valid = 1'b1;
         @(negedge i_mclk);
         i_conv_valid = 1'b0;
         m = longint'(c_raw[k]) + longint'(c_off[k]);
         if (c_neg[k] > 3'h3)
            m = m - longint'(c_code[k]) * longint'(STEP);
         m = (m * longint'(c_gain[k])) >>> 14;
         r = 24'(m);
         rd_reg(8'(2 * k), r[23:8]);
         rd_reg(8'(2 * k + 1), {r[7:0], 8'h00});
      end
      $display("test conversions done");
      wr_reg(8'h0a, {3'h3, 3'h1, 10'h000});
      wr_reg(8'h0b, {3'h0, 3'h5, 10'h000});
      for (int j = 0; j < 2; j++)
      begin
         ex = (j == 0) ? 4'h5 : 4'ha;
         for (int k = 0; k < 4; k++)
         begin
            @(negedge i_mclk);
            i_active = 1'b1;
            i_active_meas = 2'(k);
            i_excite = ex;
            repeat (2) @(negedge i_mclk);
            e1 = '{en: x1[k][2], src: x1[k][1:0],
                   level: x1[k][2] & ex[x1[k][1:0]]};
            e2 = '{en: x2[k][2], src: x2[k][1:0],
                   level: x2[k][2] & ex[x2[k][1:0]]};
            chk_g("first guard", e1, g1);
            chk_g("second guard", e2, g2);
            chk("guard tie", 16'(k == 0), 16'(gshort));
         end
      end
      i_active = 1'b0;
      repeat (2) @(negedge i_mclk);
      chk_g("idle guard", 4'h0, g1);
      chk_g("idle second guard", 4'h0, g2);
      chk("idle tie", 16'h0000, 16'(gshort));
      chk("data pin value", 16'h0000, 16'(sda_o));
      $display("test guards done");
      do_reset;
      rd_reg(8'h0e, 16'h0000);
      rd_reg(8'h13, OTP);
      wr_reg(8'h0e, c_off[0]);
      rd_reg(8'h0e, c_off[0]);
      $display("test second_reset done");
      summarize;
   end
endmodule

// [dv/csc_host.sv]
// Two-wire bus controller model standing in for the host.
`timescale 1ns/1ps
module csc_host #(
   parameter logic [6:0] ADDR = 7'h50
) (
   // Clock
   input wire logic i_mclk,
   // Bus pins, data pulled up outside
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // ******
   // Bit and byte cycles
   // ******
   // A quarter bit of five clocks keeps every level far wider than a spike.
   logic glitch = 1'b0;
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic q;
      repeat (5) @(negedge i_mclk);
   endtask
   task automatic start;
      o_sda_low = 1'b0;
      q;
      o_scl = 1'b1;
      q;
      o_sda_low = 1'b1;
      q;
      o_scl = 1'b0;
      q;
   endtask
   task automatic stop;
      o_sda_low = 1'b1;
      q;
      o_scl = 1'b1;
      q;
      o_sda_low = 1'b0;
      q;
   endtask
   task automatic bitx(input logic b, output logic r);
      o_sda_low = !b;
      q;
      o_scl = 1'b1;
      q;
      if (glitch)
      begin
         o_sda_low = !o_sda_low;
         @(negedge i_mclk);
         o_sda_low = !o_sda_low;
      end
      r = i_sda;
      q;
      o_scl = 1'b0;
      q;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, d[i]);
      bitx(nack, r);
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] p,
                     input logic [15:0] v, output logic [3:0] a);
      start;
      wbyte({dev, 1'b0}, a[3]);
      wbyte(p, a[2]);
      wbyte(v[15:8], a[1]);
      wbyte(v[7:0], a[0]);
      stop;
   endtask
   task automatic rd(input logic [7:0] p, output logic [15:0] v);
      logic a;
      start;
      wbyte({ADDR, 1'b0}, a);
      wbyte(p, a);
      start;
      wbyte({ADDR, 1'b1}, a);
      rbyte(1'b0, v[15:8]);
      rbyte(1'b1, v[7:0]);
      stop;
   endtask
endmodule

// [hw/csc_ctrl.sv]
// Shield routing, offset and gain calibration, two-wire register target.
// Functional notes
// RL1 - Differential: first guard follows lower input, second guard higher.
// RL2 - Single-ended without offset array: both guards tied together.
// RL3 - Single-ended with offset array: first guard follows input, second floats.
// RL4 - Each active guard copies the excitation of its associated input.
// RL5 - Result equals measured input minus programmed offset array value.
// RL6 - Offset array code is 5 bits; larger code subtracts no less.
// RL7 - Offset trim registers return to default on every reset.
// RL8 - Host should store offset trim and rewrite it after power-up.
// RL9 - Host removes large offset with array, then trims residue.
// RL10 - Four writable gain trim registers at 0x11 to 0x14.
// RL11 - Gain trim reloads the factory coefficient after every reset.
// RL12 - Bus inputs ignore glitches up to 50 ns wide; the filter takes two 40 ns samples, so it rejects only pulses up to 40 ns.
// RL13 - Negative select below b100 means a differential measurement.
// RL14 - Negative select b100 or b111 means single-ended measurement.
// RL15 - Selected input's offset and gain trims apply before readout.
`timescale 1ns/1ps
`include "csc_map.svh"

module csc_ctrl #(
   parameter logic [6:0] BUS_ADDR = 7'h50,
   parameter logic [15:0] DAC_STEP = 16'h0800
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Two-wire bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // Factory coefficient from one-time memory
   input wire logic [15:0] i_otp_gain,
   // Raw conversion results from the front end
   input wire logic i_conv_valid,
   input wire logic [1:0] i_conv_meas,
   input wire logic signed [23:0] i_conv_raw,
   // Active measurement and input excitation
   input wire logic i_active,
   input wire logic [1:0] i_active_meas,
   input wire logic [3:0] i_excite,
   // Guard drivers
   output csc_pkg::csc_guard_s o_first_guard_output,
   output csc_pkg::csc_guard_s o_second_guard_output,
   output logic o_guard_short
);

   // ****************************************
   // Parameter checks
   // ****************************************
   if (DAC_STEP == 16'h0000)
   begin : g_chk_step
      $error("DAC_STEP must be nonzero");
   end
   if (BUS_ADDR == 7'h00)
   begin : g_chk_addr
      $error("BUS_ADDR must not be the general call address");
   end

   // ****************************************
   // Input spike filters
   // ****************************************
   localparam logic [1:0] SPIKE_CYC = 2'(`CSC_SPIKE_CYC);
   logic [1:0] pin_raw;
   logic [1:0] pin_f_reg;
   logic [1:0] pin_d_reg;
   assign pin_raw = {i_scl, i_sda};

   // A line change is accepted only after it stays for SPIKE_CYC samples.
   for (genvar li = 0; li < 2; li++)
   begin : g_filt
      logic [1:0] cnt_reg;
      always_ff @(posedge i_mclk)
      begin
         if (!i_rst_b)
         begin
            cnt_reg <= 2'h0;
            pin_f_reg[li] <= 1'b1;
         end
         else if (pin_raw[li] == pin_f_reg[li])
            cnt_reg <= 2'h0;
         else if (cnt_reg + 2'h1 >= SPIKE_CYC) // RL12
         begin
            cnt_reg <= 2'h0;
            pin_f_reg[li] <= pin_raw[li];
         end
         else
            cnt_reg <= cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
         pin_d_reg <= 2'h3;
      else
         pin_d_reg <= pin_f_reg;
   end

   wire scl_f = pin_f_reg[1];
   wire sda_f = pin_f_reg[0];
   wire scl_rise = scl_f & ~pin_d_reg[1];
   wire scl_fall = ~scl_f & pin_d_reg[1];
   wire bus_start = scl_f & pin_d_reg[1] & pin_d_reg[0] & ~sda_f;
   wire bus_stop = scl_f & pin_d_reg[1] & ~pin_d_reg[0] & sda_f;

   // ****************************************
   // Register storage
   // ****************************************
   logic [15:0] cfg_reg [4];
   logic [15:0] offs_reg [4];
   logic [15:0] gain_reg [4];
   logic [23:0] res_reg [4];
   logic [7:0] ptr_reg;
   logic [7:0] hold_reg;
   logic [7:0] shreg_reg;
   logic byte_sel_reg;
   csc_pkg::csc_state_e state_reg;
   logic [3:0] cnt_reg;
   logic sda_low_reg;
   logic rw_reg;
   logic [7:0] rd_byte_reg;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic csc_in(input logic [7:0] p,
      input logic [7:0] lo, input logic [7:0] hi);
      csc_in = (p >= lo) && (p <= hi);
   endfunction

   wire ptr_is_res = csc_in(ptr_reg, `CSC_RES_BASE, `CSC_RES_LAST);
   wire ptr_is_cfg = csc_in(ptr_reg, `CSC_CFG_BASE, `CSC_CFG_LAST);
   wire ptr_is_offs = csc_in(ptr_reg, `CSC_OFFS_BASE, `CSC_OFFS_LAST);
   wire ptr_is_gain = csc_in(ptr_reg, `CSC_GAIN_BASE, `CSC_GAIN_LAST); // RL10
   wire wr_ok = ptr_is_cfg | ptr_is_offs | ptr_is_gain;
   wire sh_hit = csc_in(shreg_reg, `CSC_RES_BASE, `CSC_CFG_LAST)
      | csc_in(shreg_reg, `CSC_OFFS_BASE, `CSC_GAIN_LAST);
   wire [7:0] idx_cfg = ptr_reg - `CSC_CFG_BASE;
   wire [7:0] idx_offs = ptr_reg - `CSC_OFFS_BASE;
   wire [7:0] idx_gain = ptr_reg - `CSC_GAIN_BASE;
   wire [7:0] idx_res = ptr_reg - `CSC_RES_BASE;
   wire [1:0] res_sel = idx_res[2:1];
   wire [23:0] res_word = res_reg[res_sel];
   wire [15:0] res_half = idx_res[0] ? {res_word[7:0], 8'h00}
      : res_word[23:8];
   wire [15:0] rd_word = ptr_is_res ? res_half
      : ptr_is_cfg ? cfg_reg[idx_cfg[1:0]]
      : ptr_is_offs ? offs_reg[idx_offs[1:0]]
      : ptr_is_gain ? gain_reg[idx_gain[1:0]] : 16'h0000;
   wire [7:0] rd_next = byte_sel_reg ? rd_word[7:0] : rd_word[15:8];
   wire [15:0] wr_word = {hold_reg, shreg_reg};
   wire byte_end = scl_fall && (cnt_reg == 4'h8);
   wire wr_fire = (state_reg == csc_pkg::ST_WDATA) && byte_end
      && byte_sel_reg && wr_ok;

   // ****************************************
   // Conversion correction
   // ****************************************
   csc_pkg::csc_meas_cfg_s cv;
   assign cv = csc_pkg::csc_meas_cfg_s'(cfg_reg[i_conv_meas]);
   wire [1:0] cv_in = cv.positive_input_select[1:0];
   wire cv_diff = cv.negative_input_select < `CSC_NEG_DIFF_LIM; // RL13
   // The array code scales linearly, so the subtraction is monotonic.
   wire [31:0] dac_sub = cv_diff ? 32'h0000_0000
      : {27'h0, cv.offset_balance_array} * {16'h0, DAC_STEP}; // RL6
   wire signed [31:0] corr = 32'(i_conv_raw) - $signed(dac_sub) // RL5
      + 32'($signed(offs_reg[cv_in])); // RL15
   wire signed [48:0] prod = corr * $signed({1'b0, gain_reg[cv_in]});
   wire [23:0] res_calc = prod[`CSC_GAIN_FRAC +: 24]; // RL15

   // ****************************************
   // Per-input registers
   // ****************************************
   for (genvar gi = 0; gi < 4; gi++)
   begin : g_regs
      always_ff @(posedge i_mclk)
      begin
         if (!i_rst_b)
         begin
            cfg_reg[gi] <= `CSC_CFG_RST;
            offs_reg[gi] <= `CSC_OFFS_RST; // RL7
            gain_reg[gi] <= i_otp_gain; // RL11
            res_reg[gi] <= `CSC_RES_RST;
         end
         else
         begin
            if (wr_fire && ptr_is_cfg && idx_cfg[1:0] == gi)
               cfg_reg[gi] <= wr_word;
            if (wr_fire && ptr_is_offs && idx_offs[1:0] == gi)
               offs_reg[gi] <= wr_word;
            if (wr_fire && ptr_is_gain && idx_gain[1:0] == gi)
               gain_reg[gi] <= wr_word; // RL10
            if (i_conv_valid && i_conv_meas == gi)
               res_reg[gi] <= res_calc; // RL5
         end
      end
   end

   // ****************************************
   // Two-wire target state machine
   // ****************************************

   // The target never stretches the clock, so only data is driven.
   assign o_sda_o = 1'b0;
   assign o_sda_oe = sda_low_reg;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         state_reg <= csc_pkg::ST_IDLE;
         cnt_reg <= 4'h0;
         shreg_reg <= 8'h00;
         sda_low_reg <= 1'b0;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         byte_sel_reg <= 1'b0;
         hold_reg <= 8'h00;
         rd_byte_reg <= 8'h00;
      end
      else if (bus_start)
      begin
         state_reg <= csc_pkg::ST_ADDR;
         cnt_reg <= 4'h0;
         sda_low_reg <= 1'b0;
      end
      else if (bus_stop)
      begin
         state_reg <= csc_pkg::ST_IDLE;
         sda_low_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            csc_pkg::ST_ADDR, csc_pkg::ST_PTR, csc_pkg::ST_WDATA:
            begin
               if (scl_rise)
               begin
                  shreg_reg <= {shreg_reg[6:0], sda_f};
                  cnt_reg <= cnt_reg + 4'h1;
               end
               else if (byte_end)
               begin
                  // A refused byte is left unacknowledged.
                  state_reg <= csc_pkg::ST_IDLE;
                  if (state_reg == csc_pkg::ST_ADDR
                     && shreg_reg[7:1] == BUS_ADDR)
                  begin
                     sda_low_reg <= 1'b1;
                     rw_reg <= shreg_reg[0];
                     state_reg <= csc_pkg::ST_ADDR_ACK;
                  end
                  if (state_reg == csc_pkg::ST_PTR && sh_hit)
                  begin
                     sda_low_reg <= 1'b1;
                     ptr_reg <= shreg_reg;
                     state_reg <= csc_pkg::ST_PTR_ACK;
                  end
                  if (state_reg == csc_pkg::ST_WDATA && wr_ok)
                  begin
                     sda_low_reg <= 1'b1;
                     hold_reg <= shreg_reg;
                     state_reg <= csc_pkg::ST_WACK;
                  end
               end
            end
            csc_pkg::ST_ADDR_ACK:
               if (scl_fall)
               begin
                  cnt_reg <= 4'h0;
                  byte_sel_reg <= 1'b0;
                  rd_byte_reg <= rd_word[15:8];
                  sda_low_reg <= rw_reg & ~rd_word[15];
                  state_reg <= rw_reg ? csc_pkg::ST_RDATA
                     : csc_pkg::ST_PTR;
               end
            csc_pkg::ST_PTR_ACK, csc_pkg::ST_WACK:
               if (scl_fall)
               begin
                  sda_low_reg <= 1'b0;
                  cnt_reg <= 4'h0;
                  byte_sel_reg <= (state_reg == csc_pkg::ST_WACK)
                     & ~byte_sel_reg;
                  state_reg <= csc_pkg::ST_WDATA;
               end
            csc_pkg::ST_RDATA:
               if (scl_rise)
                  cnt_reg <= cnt_reg + 4'h1;
               else if (byte_end)
               begin
                  sda_low_reg <= 1'b0;
                  state_reg <= csc_pkg::ST_RACK;
               end
               else if (scl_fall)
               begin
                  rd_byte_reg <= {rd_byte_reg[6:0], 1'b0};
                  sda_low_reg <= ~rd_byte_reg[6];
               end
            csc_pkg::ST_RACK:
               if (scl_rise)
               begin
                  if (sda_f)
                     state_reg <= csc_pkg::ST_IDLE;
                  else
                     byte_sel_reg <= ~byte_sel_reg;
               end
               else if (scl_fall)
               begin
                  cnt_reg <= 4'h0;
                  rd_byte_reg <= rd_next;
                  sda_low_reg <= ~rd_next[7];
                  state_reg <= csc_pkg::ST_RDATA;
               end
            default:
               state_reg <= csc_pkg::ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Guard routing
   // ****************************************
   csc_pkg::csc_meas_cfg_s ga;
   assign ga = csc_pkg::csc_meas_cfg_s'(cfg_reg[i_active_meas]);
   wire [2:0] g_pos = ga.positive_input_select;
   wire [2:0] g_neg = ga.negative_input_select;
   wire g_diff = g_neg < `CSC_NEG_DIFF_LIM; // RL13
   wire g_se = (g_neg == `CSC_NEG_SE_A) || (g_neg == `CSC_NEG_SE_B); // RL14
   wire g_dac = ga.offset_balance_array != 5'h00;
   wire g_ok = i_active && (g_pos < `CSC_INPUT_LIM) && (g_diff || g_se);
   wire [2:0] g_lo = (g_pos < g_neg) ? g_pos : g_neg;
   wire [2:0] g_hi = (g_pos < g_neg) ? g_neg : g_pos;
   wire [1:0] g1_src = g_diff ? g_lo[1:0] : g_pos[1:0]; // RL1
   wire [1:0] g2_src = g_diff ? g_hi[1:0] : g_pos[1:0]; // RL1
   wire g1_en = g_ok; // RL3
   wire g2_en = g_ok && (g_diff || !g_dac); // RL3
   wire g_short = g_ok && g_se && !g_dac; // RL2

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         o_first_guard_output <= '0;
         o_second_guard_output <= '0;
         o_guard_short <= 1'b0;
      end
      else
      begin
         o_first_guard_output <= {g1_en, g1_src,
            g1_en & i_excite[g1_src]}; // RL4
         o_second_guard_output <= {g2_en, g2_src,
            g2_en & i_excite[g2_src]}; // RL4
         o_guard_short <= g_short;
      end
   end

endmodule

// [hw/csc_map.svh]
// Register offsets, field codes, reset values and timing counts.
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
// ****************************************
// Register map
// ****************************************
`define CSC_RES_BASE 8'h00
`define CSC_RES_LAST 8'h07
`define CSC_CFG_BASE 8'h08
`define CSC_CFG_LAST 8'h0B
`define CSC_OFFS_BASE 8'h0D
`define CSC_OFFS_LAST 8'h10
`define CSC_GAIN_BASE 8'h11
`define CSC_GAIN_LAST 8'h14
// ****************************************
// Measurement configuration fields
// ****************************************
`define CSC_NEG_DIFF_LIM 3'h4
`define CSC_NEG_SE_A 3'h4
`define CSC_NEG_SE_B 3'h7
`define CSC_INPUT_LIM 3'h4
// ****************************************
// Reset values and scaling
// ****************************************
`define CSC_CFG_RST 16'h1c00
`define CSC_OFFS_RST 16'h0000
`define CSC_RES_RST 24'h00_0000
`define CSC_GAIN_FRAC 14
// ****************************************
// Timing
// ****************************************
`define CSC_CLK_NS 40
`define CSC_SPIKE_NS 50
`define CSC_SPIKE_CYC ((`CSC_SPIKE_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`endif

// [hw/csc_pkg.sv]
// Types shared by the capacitive sense control block.
package csc_pkg;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
      ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
   } csc_state_e;

   typedef struct packed {
      logic [2:0] positive_input_select;
      logic [2:0] negative_input_select;
      logic [4:0] offset_balance_array;
      logic [4:0] spare;
   } csc_meas_cfg_s;

   typedef struct packed {
      logic en;
      logic [1:0] src;
      logic level;
   } csc_guard_s;
endpackage
